// File: clock_irq_pkg.sv
package clock_irq_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] CTRL_OFFSET = 12'h008;
   localparam logic [11:0] IRQ_MASK_OFFSET = 12'h020;
   localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h024;

   // ----------------------------------------
   // field layout
   // ----------------------------------------
   localparam int NUM_READY = 7;
   localparam int NUM_EVENTS = 8;
   localparam int FLAG_LSB = 0;
   localparam int FLAG_MSB = 7;
   localparam int EN_LSB = 8;
   localparam int EN_MSB = 14;
   localparam int CLR_LSB = 16;
   localparam int CLR_MSB = 22;
   localparam int FAIL_FLAG_BIT = 7;
   localparam int FAIL_CLR_BIT = 23;

   // ----------------------------------------
   // event slots
   // ----------------------------------------
   localparam int EV_LSI = 0;
   localparam int EV_LSE = 1;
   localparam int EV_HSI = 2;
   localparam int EV_HSE = 3;
   localparam int EV_PLL = 4;
   localparam int EV_OSC14 = 5;
   localparam int EV_OSC48 = 6;
   localparam int EV_FAIL = 7;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [6:0] EN_RESET = 7'h00;
   localparam logic [7:0] FLAG_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'hff;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage

// File: event_flag_cell.sv
`timescale 1ns/1ns
module event_flag_cell (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic src,
   input wire logic arm,
   input wire logic clr,
   output logic flag
);
   logic src_prev_ff;
   logic flag_ff;
   logic rise;
   logic nxt_flag;

   // ----------------------------------------
   // edge detect and sticky flag
   // ----------------------------------------
   assign rise = src & ~src_prev_ff;
   // set wins over a clear in the same cycle
   assign nxt_flag = (rise & arm) | (flag_ff & ~clr);
   assign flag = flag_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_prev_ff <= 1'b0;
         flag_ff <= 1'b0;
      end else begin
         src_prev_ff <= src;
         flag_ff <= nxt_flag;
      end
   end
endmodule

// File: clock_ready_interrupt_reg.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
// Summary of operation
// - lowspeed internal osc turning stable with its enable set raises flag bit 0.
// - lowspeed external osc turning stable with its enable set raises flag bit 1.
// - 8 MHz internal osc turning stable with its enable set raises flag bit 2.
// - highspeed external osc turning stable with its enable set raises flag bit 3.
// - pll locking with its enable set raises flag bit 4.
// - 14 MHz internal osc ready with its enable set raises flag bit 5.
// - 48 MHz internal osc ready with enable raises bit 6; its clear bit clears it.
// - external osc failure raises flag bit 7, held until software clears it.
// - bits 8 to 14 are read/write ready enables, one enables.
// - writing one to bits 16 to 22 clears matching flag; zero does nothing.
// - writing one to bit 23 clears the failure flag; zero does nothing.
// - register sits at 0x08, resets to zero, any width, no wait states.
module clock_ready_interrupt_reg #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic lowspeed_internal_osc_ready,
   input wire logic lowspeed_external_osc_ready,
   input wire logic highspeed_internal_osc_ready,
   input wire logic highspeed_external_osc_ready,
   input wire logic pll_locked,
   input wire logic internal_osc_14mhz_ready,
   input wire logic internal_osc_48mhz_ready,
   input wire logic highspeed_external_osc_fail,
   output logic clock_irq
);
   import clock_irq_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [6:0] irq_en_ff;
   logic [6:0] nxt_irq_en;
   logic [7:0] irq_mask_ff;
   logic [7:0] nxt_irq_mask;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic [7:0] event_src;
   logic [7:0] event_arm;
   logic [7:0] event_clr;
   logic [7:0] flags;
   logic [11:0] addr_word;
   logic sel_ctrl;
   logic sel_mask;
   logic sel_status;
   logic addr_hit;
   logic setup_phase;
   logic access_phase;
   logic wr_strobe;
   logic rd_setup;
   logic wr_ctrl;
   logic wr_mask;
   logic wr_status;
   logic ctrl_lane1;
   logic ctrl_lane2;
   logic [6:0] ready_clr_ctrl;
   logic fail_clr_ctrl;
   logic [7:0] status_clr;
   logic [31:0] ctrl_rdata;
   logic [31:0] mask_rdata;
   logic [31:0] status_rdata;
   logic [31:0] read_mux;
   logic lowspeed_int_ready_flag;
   logic lowspeed_ext_ready_flag;
   logic highspeed_int_ready_flag;
   logic highspeed_ext_ready_flag;
   logic pll_lock_ready_flag;
   logic osc14_ready_flag;
   logic osc48_ready_flag;
   logic clock_fail_flag;
   logic lowspeed_int_ready_irq_en;
   logic lowspeed_ext_ready_irq_en;
   logic highspeed_int_ready_irq_en;
   logic highspeed_ext_ready_irq_en;
   logic pll_lock_ready_irq_en;
   logic osc14_ready_irq_en;
   logic osc48_ready_irq_en;

   // ----------------------------------------
   // apb phase decode
   // ----------------------------------------
   assign addr_word = 12'(paddr);
   assign sel_ctrl = (addr_word == CTRL_OFFSET);
   assign sel_mask = (addr_word == IRQ_MASK_OFFSET);
   assign sel_status = (addr_word == IRQ_STATUS_OFFSET);
   assign addr_hit = sel_ctrl | sel_mask | sel_status;
   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign pready = 1'b1;
   assign pslverr = access_phase & ~addr_hit;
   assign wr_strobe = access_phase & pwrite & pready & addr_hit;
   assign rd_setup = setup_phase & ~pwrite;

   // ----------------------------------------
   // write decode per byte lane
   // ----------------------------------------
   assign wr_ctrl = wr_strobe & sel_ctrl;
   assign wr_mask = wr_strobe & sel_mask & pstrb[0];
   assign wr_status = wr_strobe & sel_status & pstrb[0];
   assign ctrl_lane1 = wr_ctrl & pstrb[1];
   assign ctrl_lane2 = wr_ctrl & pstrb[2];
   assign ready_clr_ctrl = pwdata[CLR_MSB:CLR_LSB] & {7{ctrl_lane2}};
   assign fail_clr_ctrl = pwdata[FAIL_CLR_BIT] & ctrl_lane2;
   assign status_clr = pwdata[FLAG_MSB:FLAG_LSB] & {8{wr_status}};

   // ----------------------------------------
   // ready enables
   // ----------------------------------------
   assign nxt_irq_en = ctrl_lane1 ? pwdata[EN_MSB:EN_LSB] : irq_en_ff;
   assign lowspeed_int_ready_irq_en = irq_en_ff[EV_LSI];
   assign lowspeed_ext_ready_irq_en = irq_en_ff[EV_LSE];
   assign highspeed_int_ready_irq_en = irq_en_ff[EV_HSI];
   assign highspeed_ext_ready_irq_en = irq_en_ff[EV_HSE];
   assign pll_lock_ready_irq_en = irq_en_ff[EV_PLL];
   assign osc14_ready_irq_en = irq_en_ff[EV_OSC14];
   assign osc48_ready_irq_en = irq_en_ff[EV_OSC48];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_ff <= EN_RESET;
      end else begin
         irq_en_ff <= nxt_irq_en;
      end
   end

   // ----------------------------------------
   // interrupt mask
   // ----------------------------------------
   assign nxt_irq_mask = wr_mask ? pwdata[FLAG_MSB:FLAG_LSB] : irq_mask_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_ff <= MASK_RESET;
      end else begin
         irq_mask_ff <= nxt_irq_mask;
      end
   end

   // ----------------------------------------
   // event sources, arming and clears
   // ----------------------------------------
   assign event_src[EV_LSI] = lowspeed_internal_osc_ready;
   assign event_src[EV_LSE] = lowspeed_external_osc_ready;
   assign event_src[EV_HSI] = highspeed_internal_osc_ready;
   assign event_src[EV_HSE] = highspeed_external_osc_ready;
   assign event_src[EV_PLL] = pll_locked;
   assign event_src[EV_OSC14] = internal_osc_14mhz_ready;
   assign event_src[EV_OSC48] = internal_osc_48mhz_ready;
   assign event_src[EV_FAIL] = highspeed_external_osc_fail;

   assign event_arm[EV_LSI] = lowspeed_int_ready_irq_en;
   assign event_arm[EV_LSE] = lowspeed_ext_ready_irq_en;
   assign event_arm[EV_HSI] = highspeed_int_ready_irq_en;
   assign event_arm[EV_HSE] = highspeed_ext_ready_irq_en;
   assign event_arm[EV_PLL] = pll_lock_ready_irq_en;
   assign event_arm[EV_OSC14] = osc14_ready_irq_en;
   assign event_arm[EV_OSC48] = osc48_ready_irq_en;
   // failure flag is always armed
   assign event_arm[EV_FAIL] = 1'b1;

   assign event_clr[6:0] = ready_clr_ctrl | status_clr[6:0];
   assign event_clr[EV_FAIL] = fail_clr_ctrl | status_clr[EV_FAIL];

   // ----------------------------------------
   // sticky event flags
   // ----------------------------------------
   // rising edge of source sets, clear drops, set wins
   event_flag_cell u_lowspeed_int_cell (
      .pclk(pclk),
      .presetn(presetn),
      .src(event_src[EV_LSI]),
      .arm(event_arm[EV_LSI]),
      .clr(event_clr[EV_LSI]),
      .flag(flags[EV_LSI])
   );

   event_flag_cell u_lowspeed_ext_cell (
      .pclk(pclk),
      .presetn(presetn),
      .src(event_src[EV_LSE]),
      .arm(event_arm[EV_LSE]),
      .clr(event_clr[EV_LSE]),
      .flag(flags[EV_LSE])
   );

   event_flag_cell u_highspeed_int_cell (
      .pclk(pclk),
      .presetn(presetn),
      .src(event_src[EV_HSI]),
      .arm(event_arm[EV_HSI]),
      .clr(event_clr[EV_HSI]),
      .flag(flags[EV_HSI])
   );

   event_flag_cell u_highspeed_ext_cell (
      .pclk(pclk),
      .presetn(presetn),
      .src(event_src[EV_HSE]),
      .arm(event_arm[EV_HSE]),
      .clr(event_clr[EV_HSE]),
      .flag(flags[EV_HSE])
   );

   event_flag_cell u_pll_lock_cell (
      .pclk(pclk),
      .presetn(presetn),
      .src(event_src[EV_PLL]),
      .arm(event_arm[EV_PLL]),
      .clr(event_clr[EV_PLL]),
      .flag(flags[EV_PLL])
   );

   event_flag_cell u_osc14_cell (
      .pclk(pclk),
      .presetn(presetn),
      .src(event_src[EV_OSC14]),
      .arm(event_arm[EV_OSC14]),
      .clr(event_clr[EV_OSC14]),
      .flag(flags[EV_OSC14])
   );

   event_flag_cell u_osc48_cell (
      .pclk(pclk),
      .presetn(presetn),
      .src(event_src[EV_OSC48]),
      .arm(event_arm[EV_OSC48]),
      .clr(event_clr[EV_OSC48]),
      .flag(flags[EV_OSC48])
   );

   event_flag_cell u_clock_fail_cell (
      .pclk(pclk),
      .presetn(presetn),
      .src(event_src[EV_FAIL]),
      .arm(event_arm[EV_FAIL]),
      .clr(event_clr[EV_FAIL]),
      .flag(flags[EV_FAIL])
   );

   assign lowspeed_int_ready_flag = flags[EV_LSI];
   assign lowspeed_ext_ready_flag = flags[EV_LSE];
   assign highspeed_int_ready_flag = flags[EV_HSI];
   assign highspeed_ext_ready_flag = flags[EV_HSE];
   assign pll_lock_ready_flag = flags[EV_PLL];
   assign osc14_ready_flag = flags[EV_OSC14];
   assign osc48_ready_flag = flags[EV_OSC48];
   assign clock_fail_flag = flags[EV_FAIL];

   // ----------------------------------------
   // interrupt output
   // ----------------------------------------
   assign clock_irq = |(flags & irq_mask_ff);

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // clear bits are write-only and read as zero
   assign ctrl_rdata = {
      8'h00,
      8'h00,
      1'b0,
      osc48_ready_irq_en,
      osc14_ready_irq_en,
      pll_lock_ready_irq_en,
      highspeed_ext_ready_irq_en,
      highspeed_int_ready_irq_en,
      lowspeed_ext_ready_irq_en,
      lowspeed_int_ready_irq_en,
      clock_fail_flag,
      osc48_ready_flag,
      osc14_ready_flag,
      pll_lock_ready_flag,
      highspeed_ext_ready_flag,
      highspeed_int_ready_flag,
      lowspeed_ext_ready_flag,
      lowspeed_int_ready_flag
   };
   assign mask_rdata = {24'h00_0000, irq_mask_ff};
   assign status_rdata = {24'h00_0000, flags};
   assign read_mux = sel_ctrl ? ctrl_rdata :
                     sel_mask ? mask_rdata :
                     sel_status ? status_rdata : RDATA_RESET;
   assign nxt_prdata = rd_setup ? read_mux : prdata_ff;
   assign prdata = prdata_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= RDATA_RESET;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end
endmodule

// File: clock_ready_interrupt_reg_chk.sv
`timescale 1ns/1ns
module clock_ready_interrupt_reg_chk
   import clock_irq_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic lowspeed_internal_osc_ready,
   input wire logic lowspeed_external_osc_ready,
   input wire logic highspeed_internal_osc_ready,
   input wire logic highspeed_external_osc_ready,
   input wire logic pll_locked,
   input wire logic internal_osc_14mhz_ready,
   input wire logic internal_osc_48mhz_ready,
   input wire logic highspeed_external_osc_fail,
   input wire logic clock_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // shadow of enables, mask and sources
   // ----------------------------------------
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire ctl = paddr == ADDR_W'(CTRL_OFFSET);
   wire msk = paddr == ADDR_W'(IRQ_MASK_OFFSET);
   wire hit = ctl || msk || paddr == ADDR_W'(IRQ_STATUS_OFFSET);
   wire [7:0] src = {highspeed_external_osc_fail, internal_osc_48mhz_ready, internal_osc_14mhz_ready, pll_locked,
      highspeed_external_osc_ready, highspeed_internal_osc_ready, lowspeed_external_osc_ready,
      lowspeed_internal_osc_ready};
   logic [7:0] src_q_ff;
   logic [7:0] mask_ff;
   logic [6:0] en_ff;
   wire [7:0] arm = src & ~src_q_ff & {1'b1, en_ff};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q_ff <= 8'h00;
         mask_ff <= MASK_RESET;
         en_ff <= EN_RESET;
      end else begin
         src_q_ff <= src;
         if (wr && ctl && pstrb[1]) en_ff <= pwdata[14:8];
         if (wr && msk && pstrb[0]) mask_ff <= pwdata[7:0];
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_ready_high: assert property (pready) else $error("pready low");
   a_err_decode: assert property (pslverr == (acc && !hit)) else $error("pslverr wrong");
   a_bad_read_zero: assert property (rd && !hit |-> prdata == 32'h0000_0000) else $error("bad read data");
   a_clear_reads_zero: assert property (rd && ctl |-> prdata[31:15] == 17'h0_0000) else $error("clear bits read");
   a_enable_readback: assert property (rd && ctl |-> prdata[14:8] == en_ff) else $error("enable readback");
   a_irq_sticky: assert property (clock_irq && !wr |=> clock_irq) else $error("irq dropped");
   a_irq_no_cause: assert property (!clock_irq && !wr && arm == 8'h00 |=> !clock_irq) else $error("irq uncaused");
   a_event_sets_irq: assert property (|(arm & mask_ff) && !wr |=> clock_irq) else $error("event missed");
endmodule

bind clock_ready_interrupt_reg clock_ready_interrupt_reg_chk #(.ADDR_W(ADDR_W)) i_clock_ready_interrupt_reg_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .lowspeed_internal_osc_ready(lowspeed_internal_osc_ready), .lowspeed_external_osc_ready(lowspeed_external_osc_ready),
   .highspeed_internal_osc_ready(highspeed_internal_osc_ready),
   .highspeed_external_osc_ready(highspeed_external_osc_ready), .pll_locked(pll_locked),
   .internal_osc_14mhz_ready(internal_osc_14mhz_ready), .internal_osc_48mhz_ready(internal_osc_48mhz_ready),
   .highspeed_external_osc_fail(highspeed_external_osc_fail), .clock_irq(clock_irq));

// File: clock_ready_interrupt_reg_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module clock_ready_interrupt_reg_tb_top;
   import clock_irq_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, clock_irq, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [3:0] pstrb = 4'h0;
   logic [7:0] src = 8'h00;
   int fails = 0, check_count = 0, cyc = 0;
   clock_ready_interrupt_reg #(.ADDR_W(12)) i_clock_ready_interrupt_reg (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .lowspeed_internal_osc_ready(src[0]),
      .lowspeed_external_osc_ready(src[1]), .highspeed_internal_osc_ready(src[2]),
      .highspeed_external_osc_ready(src[3]), .pll_locked(src[4]), .internal_osc_14mhz_ready(src[5]),
      .internal_osc_48mhz_ready(src[6]), .highspeed_external_osc_fail(src[7]), .clock_irq(clock_irq));
   initial begin
      forever #10 pclk = ~pclk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         complete_run();
      end
   end
   // ----------------------------------------
   // apb transfer
   // ----------------------------------------
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(input logic [7:0] v);
      @(posedge pclk);
      src <= v;
      repeat (2) @(posedge pclk);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
      `CHK(rd, 32'h0000_0000)
      `CHK(clock_irq, 1'b0)
      xfer(1'b0, IRQ_MASK_OFFSET, 32'h0000_0000, 4'h0);
      `CHK(rd, {24'h00_0000, MASK_RESET})
      xfer(1'b1, CTRL_OFFSET, 32'h0000_7f00, 4'h1);
      xfer(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
      `CHK(rd, 32'h0000_0000)
      xfer(1'b1, CTRL_OFFSET, 32'h0000_7f00, 4'h2);
      xfer(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
      `CHK(rd, 32'h0000_7f00)
      $display("test reset and enables done");
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i);
         xfer(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
         `CHK(rd, 32'h0000_7f00 | (32'h1 << i))
         `CHK(clock_irq, 1'b1)
         xfer(1'b1, CTRL_OFFSET, 32'h0000_7f00, 4'h6);
         xfer(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
         `CHK(rd, 32'h0000_7f00 | (32'h1 << i))
         xfer(1'b1, CTRL_OFFSET, 32'h0000_7f00 | (32'h1 << (16 + i)), 4'h6);
         xfer(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
         `CHK(rd, 32'h0000_7f00)
         `CHK(clock_irq, 1'b0)
         pulse(8'h00);
      end
      $display("test set and clear done");
      xfer(1'b1, CTRL_OFFSET, 32'h0000_0000, 4'h2);
      pulse(8'h7f);
      xfer(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
      `CHK(rd, 32'h0000_0000)
      pulse(8'h00);
      xfer(1'b1, IRQ_MASK_OFFSET, 32'h0000_0000, 4'h1);
      xfer(1'b0, IRQ_MASK_OFFSET, 32'h0000_0000, 4'h0);
      `CHK(rd, 32'h0000_0000)
      pulse(8'h80);
      `CHK(clock_irq, 1'b0)
      xfer(1'b0, IRQ_STATUS_OFFSET, 32'h0000_0000, 4'h0);
      `CHK(rd[7:0], 8'h80)
      xfer(1'b1, IRQ_STATUS_OFFSET, 32'h0000_0080, 4'h1);
      xfer(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
      `CHK(rd, 32'h0000_0000)
      xfer(1'b1, IRQ_MASK_OFFSET, 32'h0000_00ff, 4'h1);
      $display("test disable and mask done");
      xfer(1'b1, CTRL_OFFSET, 32'h0000_0100, 4'h2);
      pulse(8'h01);
      `CHK(clock_irq, 1'b1)
      src <= 8'h00;
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      `CHK(clock_irq, 1'b0)
      xfer(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
      `CHK(rd, 32'h0000_0000)
      xfer(1'b0, IRQ_MASK_OFFSET, 32'h0000_0000, 4'h0);
      `CHK(rd, {24'h00_0000, MASK_RESET})
      $display("test mid-run reset done");
      xfer(1'b0, 12'h030, 32'h0000_0000, 4'h0);
      `CHK({er, rd}, {1'b1, 32'h0000_0000})
      xfer(1'b0, 12'h009, 32'h0000_0000, 4'h0);
      `CHK({er, rd}, {1'b1, 32'h0000_0000})
      $display("test unmapped done");
      complete_run();
   end
endmodule
